//--- mcr_bench.sv
// self-checking bench for the measurement control register
`timescale 1ns/1ps
module mcr_bench;
    import mcr_pkg::*;
    logic        clk = 1'b0;
    logic        srst = 1'b1;
    logic [3:0]  addr;
    logic [15:0] wdata, rdata, q;
    logic        wr, rd, pin, oe, osc_on, osc_rdy, cont, irq;
    logic        cmp = 1'b0, up = 1'b0, slow = 1'b0, req = 1'b0;
    logic [2:0]  ev = 3'b000;
    logic [3:0]  cal;
    int          n_fail = 0;
    int          compares = 0;
    int          k;
    logic [15:0] mctl [5] = '{16'h0c00, 16'h0c00, 16'h0800, 16'h0800, 16'h0400};
    logic [3:0]  mvec [5] = '{4'b1011, 4'b0101, 4'b0111, 4'b1001, 4'b1100};
    mcr_host_model host (.i_core_clk(clk), .i_rdata(rdata), .o_addr(addr), .o_wdata(wdata),
        .o_wr(wr), .o_rd(rd));
    mcr_top dut (.i_core_clk(clk), .i_srst(srst), .i_addr(addr), .i_wdata(wdata), .i_wr(wr),
        .i_rd(rd), .o_rdata(rdata), .i_comparator(cmp), .i_upstream(up), .i_slow_clk(slow),
        .i_osc_request(req), .i_meas_done(ev[0]), .i_cycle_done(ev[1]), .i_error(ev[2]),
        .o_monitor_pin(pin), .o_monitor_pin_oe(oe), .o_osc_on(osc_on), .o_osc_ready(osc_rdy),
        .o_cont_event_timing(cont), .o_cal_period(cal), .o_irq(irq));
    initial forever #2.5 clk = ~clk;
    // slow clock compressed so the longest settle stays short
    initial forever #40 slow = ~slow;
    task automatic chk(input logic [15:0] s, input logic [15:0] e);
        compares++;
        if (s !== e)
        begin
            n_fail++;
            $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task automatic rc(input logic [3:0] a, input logic [15:0] e);
        host.rd(a, q);
        chk(q, e);
    endtask
    task automatic w(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic pulse(input logic [2:0] e);
        @(posedge clk) ev <= e;
        @(posedge clk) ev <= 3'b000;
    endtask
    task automatic settle(input logic [2:0] c, input int n);
        @(negedge slow);
        host.wr(MCR_ADDR_CTRL, {9'h000, c, 4'h0});
        req <= (c < 3'd5);
        k = 0;
        while (osc_rdy !== 1'b1 && k < 300)
        begin
            @(posedge slow);
            k++;
        end
        chk(16'(k - 1), 16'(n));
        @(posedge clk) req <= 1'b0;
        w(4);
        chk(16'({osc_on, osc_rdy}), (c > 3'd4) ? 16'h0003 : 16'h0000);
    endtask
    task automatic tally_and_finish;
        $display("compares=%0d n_fail=%0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    initial
    begin
        #100us;
        n_fail++;
        tally_and_finish();
    end
    initial
    begin
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        rc(MCR_ADDR_CTRL, 16'h0000);
        host.wr(4'h7, 16'hffff);
        rc(4'h7, 16'h0000);
        host.wr(MCR_ADDR_STATUS, 16'h000f);
        rc(MCR_ADDR_STATUS, 16'h0000);
        host.wr(MCR_ADDR_CTRL, 16'hffff);
        rc(MCR_ADDR_CTRL, 16'h0fff);
        chk(16'({oe, cont, cal}), 16'h003f);
        $display("map test done");
        for (int i = 0; i < 5; i++)
        begin
            host.wr(MCR_ADDR_CTRL, mctl[i]);
            @(posedge clk) {cmp, up} <= mvec[i][3:2];
            w(5);
            chk(16'({pin, oe}), 16'(mvec[i][1:0]));
        end
        $display("monitor test done");
        settle(3'd0, 16);
        settle(3'd1, 48);
        settle(3'd2, 96);
        settle(3'd3, 128);
        settle(3'd4, 168);
        settle(3'd5, 16);
        host.wr(MCR_ADDR_CTRL, 16'h0000);
        rc(MCR_ADDR_STATUS, 16'h0008);
        $display("settle test done");
        host.wr(MCR_ADDR_CLEAR, 16'h000f);
        rc(MCR_ADDR_STATUS, 16'h0000);
        host.wr(MCR_ADDR_IRQ_EN, 16'h000f);
        host.wr(MCR_ADDR_CTRL, 16'h0200);
        pulse(3'b001);
        w(2);
        chk(16'(irq), 16'h0001);
        rc(MCR_ADDR_STATUS, 16'h0001);
        host.wr(MCR_ADDR_CLEAR, 16'h0001);
        w(2);
        chk(16'(irq), 16'h0000);
        // event and clear land on the same edge: the event must survive
        fork
            host.wr(MCR_ADDR_CLEAR, 16'h0001);
            pulse(3'b001);
        join
        rc(MCR_ADDR_STATUS, 16'h0001);
        host.wr(MCR_ADDR_CLEAR, 16'h0001);
        pulse(3'b010);
        rc(MCR_ADDR_STATUS, 16'h0000);
        host.wr(MCR_ADDR_CTRL, 16'h0080);
        host.wr(MCR_ADDR_IRQ_EN, 16'h0000);
        pulse(3'b110);
        w(2);
        chk(16'(irq), 16'h0000);
        rc(MCR_ADDR_STATUS, 16'h0006);
        host.wr(MCR_ADDR_IRQ_EN, 16'h000f);
        w(2);
        chk(16'(irq), 16'h0000);
        host.wr(MCR_ADDR_CTRL, 16'h0280);
        w(2);
        chk(16'(irq), 16'h0001);
        $display("irq test done");
        tally_and_finish();
    end
endmodule // mcr_bench
bind mcr_top mcr_top_chk u_chk (.i_core_clk(i_core_clk), .i_srst(i_srst), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_comparator(i_comparator), .i_upstream(i_upstream),
    .o_monitor_pin(o_monitor_pin), .o_monitor_pin_oe(o_monitor_pin_oe), .o_osc_on(o_osc_on),
    .o_osc_ready(o_osc_ready), .o_irq(o_irq));

//--- mcr_host_model.sv
// host side model that drives the register port
`timescale 1ns/1ps
module mcr_host_model (
    input  wire logic        i_core_clk,
    input  wire logic [15:0] i_rdata,
    output logic      [3:0]  o_addr,
    output logic      [15:0] o_wdata,
    output logic             o_wr,
    output logic             o_rd
);
    initial {o_addr, o_wdata, o_wr, o_rd} = '0;
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge i_core_clk);
        {o_addr, o_wdata, o_wr} <= {a, d, 1'b1};
        @(posedge i_core_clk);
        // released data shows its inverse, never a stale copy
        {o_wdata, o_wr} <= {~d, 1'b0};
    endtask
    task automatic rd(input logic [3:0] a, output logic [15:0] q);
        @(posedge i_core_clk);
        {o_addr, o_rd} <= {a, 1'b1};
        @(posedge i_core_clk);
        o_rd <= 1'b0;
        @(posedge i_core_clk);
        q = i_rdata;
    endtask
endmodule // mcr_host_model

//--- mcr_pkg.sv
// package for the measurement control register block
//------------------------------------------------------------
// Behaviour
//------------------------------------------------------------
// Behaviour
// (RULE1) select bit picks monitor pin source, only while pin output enable is set
// (RULE2) select at 1 drives the pin with live comparator output
// (RULE3) select at 0 drives the pin with launch direction
// (RULE4) direction high for upstream, low for downstream measurements
// (RULE5) settling code 0-4 gives 16/48/96/128/168 slow cycles, 5-7 oscillator always on
// (RULE6) all interrupt sources combine onto one pin, gated by interrupt enable
package mcr_pkg;
    //------------------------------------------------------------
    // register map
    //------------------------------------------------------------
    localparam logic [3:0]  MCR_ADDR_CTRL     = 4'h0;
    localparam logic [3:0]  MCR_ADDR_STATUS   = 4'h1;
    localparam logic [3:0]  MCR_ADDR_CLEAR    = 4'h2;
    localparam logic [3:0]  MCR_ADDR_IRQ_EN   = 4'h3;
    localparam logic [15:0] MCR_CTRL_RESET    = 16'h0000;
    localparam logic [15:0] MCR_CTRL_WMASK    = 16'h0fff;
    localparam int          MCR_BIT_PIN_OE    = 11;
    localparam int          MCR_BIT_PIN_SEL   = 10;
    localparam int          MCR_BIT_IRQ_EN    = 9;
    localparam int          MCR_BIT_CONT_ET   = 8;
    localparam int          MCR_BIT_CYC_IRQ   = 7;
    localparam int          MCR_SETTLE_LSB    = 4;
    localparam int          MCR_CAL_LSB       = 0;
    localparam int          MCR_NUM_EVENTS    = 4;
    localparam logic [3:0]  MCR_EVENT_RESET   = 4'h0;
    //------------------------------------------------------------
    // settling counts in slow clock cycles
    //------------------------------------------------------------
    localparam logic [7:0]  MCR_SETTLE_C0     = 8'h10;
    localparam logic [7:0]  MCR_SETTLE_C1     = 8'h30;
    localparam logic [7:0]  MCR_SETTLE_C2     = 8'h60;
    localparam logic [7:0]  MCR_SETTLE_C3     = 8'h80;
    localparam logic [7:0]  MCR_SETTLE_C4     = 8'ha8;

    typedef struct packed {
        logic       monitor_pin_output_enable;
        logic       monitor_pin_source_select;
        logic       irq_en;
        logic       continuous_event_timing;
        logic       per_cycle_irq;
        logic [2:0] settle;
        logic [3:0] cal_period;
    } mcr_ctrl_s;

    typedef enum logic [2:0] {
        MCR_ST_IDLE   = 3'b001,
        MCR_ST_SETTLE = 3'b010,
        MCR_ST_READY  = 3'b100
    } mcr_state_e;
endpackage

//--- mcr_settle.sv
// oscillator settling timer driven by slow clock ticks
`timescale 1ns/1ps
module mcr_settle
    import mcr_pkg::*;
(
    input  wire logic       i_core_clk,
    input  wire logic       i_srst,
    input  wire logic [2:0] i_settle_code,
    input  wire logic       i_osc_request,
    input  wire logic       i_slow_tick,
    output logic            o_osc_on,
    output logic            o_osc_ready,
    output logic            o_ready_pulse
);
    mcr_state_e state_r;
    mcr_state_e state_nxt;
    logic [7:0] cnt_r;
    logic [7:0] cnt_nxt;
    logic [7:0] target;
    logic       always_on;

    always_comb
    begin
        always_on = 1'b0;
        case (i_settle_code)                                   // [RULE5]
            3'd0:    target = MCR_SETTLE_C0;
            3'd1:    target = MCR_SETTLE_C1;
            3'd2:    target = MCR_SETTLE_C2;
            3'd3:    target = MCR_SETTLE_C3;
            3'd4:    target = MCR_SETTLE_C4;
            default:
            begin
                target    = MCR_SETTLE_C0;
                always_on = 1'b1;                              // [RULE5]
            end
        endcase
    end

    always_comb
    begin
        state_nxt     = state_r;
        cnt_nxt       = cnt_r;
        o_ready_pulse = 1'b0;
        case (state_r)
            MCR_ST_IDLE:
            begin
                cnt_nxt = 8'h00;
                if (i_osc_request || always_on)
                    state_nxt = MCR_ST_SETTLE;
            end
            MCR_ST_SETTLE:
            begin
                if (!(i_osc_request || always_on))
                    state_nxt = MCR_ST_IDLE;
                else if (i_slow_tick)
                begin
                    cnt_nxt = cnt_r + 8'h01;
                    // wait the full count of slow cycles before declaring ready
                    if (cnt_nxt >= target)
                    begin
                        state_nxt     = MCR_ST_READY;             // [RULE5]
                        o_ready_pulse = 1'b1;
                    end
                end
            end
            MCR_ST_READY:
            begin
                if (!(i_osc_request || always_on))
                    state_nxt = MCR_ST_IDLE;
            end
            default: state_nxt = MCR_ST_IDLE;
        endcase
    end

    always_ff @(posedge i_core_clk)
    begin
        if (i_srst)
        begin
            state_r <= MCR_ST_IDLE;
            cnt_r   <= 8'h00;
        end
        else
        begin
            state_r <= state_nxt;
            cnt_r   <= cnt_nxt;
        end
    end

    assign o_osc_on    = (state_r != MCR_ST_IDLE);
    assign o_osc_ready = (state_r == MCR_ST_READY);
endmodule // mcr_settle

//--- mcr_top.sv
// calibration and control register with monitor pin, settling timer and interrupt
`timescale 1ns/1ps
module mcr_top
    import mcr_pkg::*;
(
    input  wire logic        i_core_clk,
    input  wire logic        i_srst,
    input  wire logic [3:0]  i_addr,
    input  wire logic [15:0] i_wdata,
    input  wire logic        i_wr,
    input  wire logic        i_rd,
    output logic      [15:0] o_rdata,
    input  wire logic        i_comparator,
    input  wire logic        i_upstream,
    input  wire logic        i_slow_clk,
    input  wire logic        i_osc_request,
    input  wire logic        i_meas_done,
    input  wire logic        i_cycle_done,
    input  wire logic        i_error,
    output logic             o_monitor_pin,
    output logic             o_monitor_pin_oe,
    output logic             o_osc_on,
    output logic             o_osc_ready,
    output logic             o_cont_event_timing,
    output logic [3:0]       o_cal_period,
    output logic             o_irq
);
    //------------------------------------------------------------
    // input synchronisers
    //------------------------------------------------------------
    logic [2:0] sync1_r;
    logic [2:0] sync2_r;
    logic       slow_prev_r;
    logic       slow_tick;

    always_ff @(posedge i_core_clk)
    begin
        if (i_srst)
        begin
            sync1_r     <= 3'h0;
            sync2_r     <= 3'h0;
            slow_prev_r <= 1'b0;
        end
        else
        begin
            sync1_r     <= {i_slow_clk, i_upstream, i_comparator};
            sync2_r     <= sync1_r;
            slow_prev_r <= sync2_r[2];
        end
    end

    assign slow_tick = sync2_r[2] & ~slow_prev_r;

    //------------------------------------------------------------
    // write decode
    //------------------------------------------------------------
    // one strobe per writable register; index 1 is read only and has none
    logic wr_ctrl;
    logic wr_clear;
    logic wr_ien;

    always_comb
    begin
        wr_ctrl  = i_wr && (i_addr == MCR_ADDR_CTRL);
        wr_clear = i_wr && (i_addr == MCR_ADDR_CLEAR);
        wr_ien   = i_wr && (i_addr == MCR_ADDR_IRQ_EN);
    end

    //------------------------------------------------------------
    // control register
    //------------------------------------------------------------
    mcr_ctrl_s ctrl_r;
    mcr_ctrl_s ctrl_nxt;

    always_comb
    begin
        ctrl_nxt = ctrl_r;
        if (wr_ctrl)
            ctrl_nxt = mcr_ctrl_s'(i_wdata[11:0]);
    end

    always_ff @(posedge i_core_clk)
    begin
        if (i_srst)
            ctrl_r <= mcr_ctrl_s'(MCR_CTRL_RESET[11:0]);
        else
            ctrl_r <= ctrl_nxt;
    end

    //------------------------------------------------------------
    // monitor pin
    //------------------------------------------------------------
    logic mon_r;
    logic mon_nxt;
    logic mon_oe_r;
    logic mon_oe_nxt;

    always_comb
    begin
        mon_oe_nxt = ctrl_r.monitor_pin_output_enable;         // [RULE1]
        if (!ctrl_r.monitor_pin_output_enable)
            mon_nxt = 1'b0;                                    // [RULE1]
        else if (ctrl_r.monitor_pin_source_select)
            mon_nxt = sync2_r[0];                              // [RULE2]
        else
            mon_nxt = sync2_r[1];                              // [RULE3] [RULE4]
    end

    always_ff @(posedge i_core_clk)
    begin
        if (i_srst)
        begin
            mon_r    <= 1'b0;
            mon_oe_r <= 1'b0;
        end
        else
        begin
            mon_r    <= mon_nxt;
            mon_oe_r <= mon_oe_nxt;
        end
    end

    assign o_monitor_pin    = mon_r;
    assign o_monitor_pin_oe = mon_oe_r;

    //------------------------------------------------------------
    // settling timer
    //------------------------------------------------------------
    logic ready_pulse;

    mcr_settle u_settle
    (
        .i_core_clk    (i_core_clk),
        .i_srst        (i_srst),
        .i_settle_code (ctrl_r.settle),
        .i_osc_request (i_osc_request),
        .i_slow_tick   (slow_tick),
        .o_osc_on      (o_osc_on),
        .o_osc_ready   (o_osc_ready),
        .o_ready_pulse (ready_pulse)
    );

    //------------------------------------------------------------
    // interrupt status, clear and enable
    //------------------------------------------------------------
    logic [MCR_NUM_EVENTS-1:0] stat_r;
    logic [MCR_NUM_EVENTS-1:0] stat_nxt;
    logic [MCR_NUM_EVENTS-1:0] ien_r;
    logic [MCR_NUM_EVENTS-1:0] ien_nxt;
    logic [MCR_NUM_EVENTS-1:0] events;
    logic [MCR_NUM_EVENTS-1:0] clr;

    // per-cycle completions only raise an event when the per-cycle option is on
    assign events = {ready_pulse, i_error, i_cycle_done & ctrl_r.per_cycle_irq, i_meas_done};
    assign clr    = wr_clear ? i_wdata[MCR_NUM_EVENTS-1:0]
                             : '0;

    generate
        for (genvar g = 0; g < MCR_NUM_EVENTS; g++)
        begin : g_evt
            // set beats a clear in the same cycle so no event is lost
            always_comb
            begin
                stat_nxt[g] = events[g] | (stat_r[g] & ~clr[g]);
            end
        end
    endgenerate

    always_comb
    begin
        ien_nxt = ien_r;
        if (wr_ien)
            ien_nxt = i_wdata[MCR_NUM_EVENTS-1:0];
    end

    always_ff @(posedge i_core_clk)
    begin
        if (i_srst)
        begin
            stat_r <= MCR_EVENT_RESET;
            ien_r  <= MCR_EVENT_RESET;
        end
        else
        begin
            stat_r <= stat_nxt;
            ien_r  <= ien_nxt;
        end
    end

    assign o_irq = ctrl_r.irq_en & (|(stat_r & ien_r));        // [RULE6]

    //------------------------------------------------------------
    // read port
    //------------------------------------------------------------
    logic [15:0] rdata_r;
    logic [15:0] rdata_nxt;

    always_comb
    begin
        // reads have no side effects; status bits clear only through the clear register
        rdata_nxt = 16'h0000;
        if (i_rd)
        begin
            case (i_addr)
                MCR_ADDR_CTRL:   rdata_nxt = {4'h0, ctrl_r};
                MCR_ADDR_STATUS: rdata_nxt = {12'h000, stat_r};
                MCR_ADDR_IRQ_EN: rdata_nxt = {12'h000, ien_r};
                default:         rdata_nxt = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge i_core_clk)
    begin
        if (i_srst)
            rdata_r <= 16'h0000;
        else
            rdata_r <= rdata_nxt;
    end

    assign o_rdata             = rdata_r;
    assign o_cont_event_timing = ctrl_r.continuous_event_timing;
    assign o_cal_period        = ctrl_r.cal_period;
endmodule // mcr_top

//--- mcr_top_assertions.sv
// concurrent checks on the control register ports
`timescale 1ns/1ps
module mcr_top_chk
    import mcr_pkg::*;
(
    input  wire logic        i_core_clk,
    input  wire logic        i_srst,
    input  wire logic [3:0]  i_addr,
    input  wire logic [15:0] i_wdata,
    input  wire logic        i_wr,
    input  wire logic        i_comparator,
    input  wire logic        i_upstream,
    input  wire logic        o_monitor_pin,
    input  wire logic        o_monitor_pin_oe,
    input  wire logic        o_osc_on,
    input  wire logic        o_osc_ready,
    input  wire logic        o_irq
);
    // shadow of the control word, same update edge as the design's copy
    // starts at the reset value so $past is defined on the first unmasked edge
    logic [15:0] ctl_r = 16'h0000;
    logic [15:0] ctl_nxt;
    always_comb ctl_nxt = (i_wr && i_addr == MCR_ADDR_CTRL) ? (i_wdata & MCR_CTRL_WMASK) : ctl_r;
    always_ff @(posedge i_core_clk) ctl_r <= i_srst ? '0 : ctl_nxt;
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (i_srst);
    property p_off; !o_monitor_pin_oe |-> !o_monitor_pin; endproperty
    property p_oe; o_monitor_pin_oe == $past(ctl_r[11]); endproperty
    property p_cmp; o_monitor_pin_oe && $past(ctl_r[10]) |-> o_monitor_pin == $past(i_comparator, 3);
    endproperty
    property p_dir; o_monitor_pin_oe && !$past(ctl_r[10]) |-> o_monitor_pin == $past(i_upstream, 3);
    endproperty
    property p_cont; $past(ctl_r[6:4]) > 3'd4 |-> o_osc_on; endproperty
    property p_rdy; o_osc_ready |-> o_osc_on && $past(o_osc_on); endproperty
    property p_irq; o_irq |-> ctl_r[9]; endproperty
    a_off: assert property (p_off) else $error("pin driven while disabled");
    a_oe: assert property (p_oe) else $error("pin enable mismatch");
    a_cmp: assert property (p_cmp) else $error("pin not comparator");
    a_dir: assert property (p_dir) else $error("pin not direction");
    a_cont: assert property (p_cont) else $error("oscillator off");
    a_rdy: assert property (p_rdy) else $error("ready without osc");
    a_irq: assert property (p_irq) else $error("irq while gated");
    c_pin: cover property (o_monitor_pin_oe && o_monitor_pin);
    c_rdy: cover property (o_osc_ready);
    c_irq: cover property (o_irq);
endmodule // mcr_top_chk
